// *** verilog/gyro_spi_pkg.sv ***
// Shared constants for the rate sensor serial register port.
package gyro_spi_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SAMPLE_RATE_SPS = 2429;
  // Longest whole count of cycles that still meets the sample rate.
  localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_SPS;
  localparam int DRDY_TIME_NS    = 1000;
  localparam int DRDY_CYCLES     = (DRDY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_TIME_US   = 9;
  localparam int SCLK_MAX_KHZ    = 2500;

  // ---------------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT     = 15;
  localparam int ADDR_MSB   = 14;
  localparam int ADDR_LSB   = 8;
  localparam int OUT_ND_BIT = 15;
  localparam int OUT_EA_BIT = 14;

  // ---------------------------------------------------------------------------
  // Byte addresses of the lower bytes of the readable output words
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ADDR_RATE     = 7'h04;
  localparam logic [6:0] ADDR_RATE_EXT = 7'h06;
  localparam logic [6:0] ADDR_TEMP     = 7'h0C;

  // ---------------------------------------------------------------------------
  // Reset values and full frame bit count
  // ---------------------------------------------------------------------------
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [5:0]  SEL_RESET   = 6'h00;
  localparam logic [4:0]  COUNT_RESET = 5'h00;
  localparam logic [4:0]  COUNT_FULL  = 5'h10;

  // Frame engine states.
  typedef enum logic [1:0] {
    FRAME_IDLE  = 2'b01,
    FRAME_SHIFT = 2'b10
  } frame_state_t;

endpackage

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/10ps
module pin_sync #(
  parameter int          WIDTH    = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q       <= RESET_VAL;
      pin_sync_out <= RESET_VAL;
    end else begin
      meta_q       <= pin_in;
      pin_sync_out <= meta_q;
    end
  end

endmodule // pin_sync

// *** verilog/gyro_spi_register_port.sv ***
// Serial slave register port with autonomous sample cycle and data-ready line.
// How it works
// - Output data line changes only at chip select fall and after detected falling serial clock edges.
// - Input data bit is sampled on each of the first 16 detected rising serial clock edges of a frame.
// - Port is selected only while chip select is low.
// - Each sample cycle end drives a high pulse on digital line one.
// - Sample engine runs from reset with no master configuration.
// - A read request frame is answered in the following frame.
// - Next request shifts in while previous answer shifts out.
// - Requests 0x0400, 0x0600, 0x0C00 return rate, extended rate, temperature.
// - Both byte addresses of a 16-bit word select that word.
// - Answer data is driven only after a read request frame.
// - Output line is released while chip select is high.
// - MSB appears at chip select fall, later bits after falling edges.
`timescale 1ns/10ps
module gyro_spi_register_port #(
  parameter int SAMPLE_CYCLES = gyro_spi_pkg::SAMPLE_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        reset_pin_n,
  input  wire logic [13:0] rate_data,
  input  wire logic [15:0] rate_output_extended,
  input  wire logic [13:0] temp_data,
  input  wire logic        alarm_flag,
  output logic             dout,
  output logic             dout_oe,
  output logic             config_digital_line_one,
  output logic             config_digital_line_one_oe
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sclk_prev_q;
  logic       cs_n_prev_q;

  // Every pin leaves reset at its idle level, so no false clock edge follows reset.
  pin_sync #(.WIDTH(4), .RESET_VAL(4'hF)) pin_sync_i (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_in       ({reset_pin_n, sclk, cs_n, din}),
    .pin_sync_out (pins_s)
  );

  wire reset_pin_n_s = pins_s[3];
  wire sclk_s        = pins_s[2];
  wire cs_n_s        = pins_s[1];
  wire din_s         = pins_s[0];
  wire selected      = ~cs_n_s;
  wire sclk_rise     = sclk_s & ~sclk_prev_q & selected;
  wire sclk_fall     = ~sclk_s & sclk_prev_q & selected;
  wire cs_fall       = ~cs_n_s & cs_n_prev_q;
  wire cs_rise       = cs_n_s & ~cs_n_prev_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'b1;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Sample engine
  // ---------------------------------------------------------------------------
  logic [16:0] smp_cnt_q;
  logic [7:0]  drdy_cnt_q;
  logic [15:0] rate_q;
  logic [15:0] rate_ext_q;
  logic [15:0] temp_q;
  logic        line_one_q;
  logic        line_one_oe_q;

  // The reset pin restarts the sample cycle; the synchronous path keeps it glitch safe.
  wire         sample_end = reset_pin_n_s && (smp_cnt_q == 17'(SAMPLE_CYCLES - 1));
  wire [16:0]  smp_cnt_d  = (!reset_pin_n_s || sample_end) ? 17'h00000 : smp_cnt_q + 17'h00001;
  wire [7:0]   drdy_cnt_d = sample_end ? 8'(gyro_spi_pkg::DRDY_CYCLES) :
                            (drdy_cnt_q != 8'h00) ? drdy_cnt_q - 8'h01 : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smp_cnt_q  <= 17'h00000;
      drdy_cnt_q    <= 8'h00;
      line_one_q    <= 1'b0;
      line_one_oe_q <= 1'b0;
    end else begin
      smp_cnt_q     <= smp_cnt_d;
      drdy_cnt_q    <= drdy_cnt_d;
      line_one_q    <= (drdy_cnt_d != 8'h00);
      line_one_oe_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------------------
  gyro_spi_pkg::frame_state_t state_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [4:0]  bits_q;
  logic [5:0]  sel_q;
  logic        tx_valid_q;
  logic        dout_q;
  logic        dout_oe_q;

  // Both byte addresses of a word drop the byte bit and land on the same index.
  function automatic logic [5:0] word_index(input logic [6:0] byte_addr);
    word_index = byte_addr[6:1];
  endfunction

  wire [6:0]  req_addr  = rx_q[gyro_spi_pkg::ADDR_MSB:gyro_spi_pkg::ADDR_LSB];
  wire        req_read  = ~rx_q[gyro_spi_pkg::RW_BIT];
  wire        frame_ok  = cs_rise && (bits_q == gyro_spi_pkg::COUNT_FULL);
  wire        sel_rate  = (sel_q == word_index(gyro_spi_pkg::ADDR_RATE));
  wire        sel_ext   = (sel_q == word_index(gyro_spi_pkg::ADDR_RATE_EXT));
  wire        sel_temp  = (sel_q == word_index(gyro_spi_pkg::ADDR_TEMP));
  wire [15:0] tx_word   = sel_rate ? rate_q : sel_ext ? rate_ext_q :
                          sel_temp ? temp_q : gyro_spi_pkg::WORD_RESET;
  wire        load      = cs_fall && tx_valid_q;
  wire        shift_out = sclk_fall && (bits_q != gyro_spi_pkg::COUNT_RESET) &&
                          (bits_q != gyro_spi_pkg::COUNT_FULL);
  wire        in_shift  = (state_q == gyro_spi_pkg::FRAME_SHIFT);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= gyro_spi_pkg::FRAME_IDLE;
    end else begin
      unique case (state_q)
        gyro_spi_pkg::FRAME_IDLE: begin
          if (cs_fall) begin
            state_q <= gyro_spi_pkg::FRAME_SHIFT;
          end
        end
        gyro_spi_pkg::FRAME_SHIFT: begin
          if (cs_n_s) begin
            state_q <= gyro_spi_pkg::FRAME_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_q   <= gyro_spi_pkg::WORD_RESET;
      bits_q <= gyro_spi_pkg::COUNT_RESET;
    end else if (cs_fall) begin
      bits_q <= gyro_spi_pkg::COUNT_RESET;
    end else if (sclk_rise && in_shift && bits_q != gyro_spi_pkg::COUNT_FULL) begin
      rx_q   <= {rx_q[14:0], din_s};
      bits_q <= bits_q + 5'h01;
    end
  end

  // A short frame leaves no pending answer and a long frame keeps only its first 16 bits, so a stray burst cannot misalign reads.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q      <= gyro_spi_pkg::SEL_RESET;
      tx_valid_q <= 1'b0;
    end else if (cs_rise) begin
      sel_q      <= word_index(req_addr);
      tx_valid_q <= frame_ok && req_read;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_q      <= gyro_spi_pkg::WORD_RESET;
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= selected && tx_valid_q;
      if (load) begin
        tx_q   <= tx_word;
        dout_q <= tx_word[15];
      end else if (shift_out && tx_valid_q) begin
        tx_q   <= {tx_q[14:0], 1'b0};
        dout_q <= tx_q[14];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Output words, new-data flag on rate and temperature only; a fresh sample wins over a read clear
  // ---------------------------------------------------------------------------
  wire ea = alarm_flag;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_q     <= gyro_spi_pkg::WORD_RESET;
      rate_ext_q <= gyro_spi_pkg::WORD_RESET;
      temp_q     <= gyro_spi_pkg::WORD_RESET;
    end else if (sample_end) begin
      rate_q     <= {1'b1, ea, rate_data};
      rate_ext_q <= rate_output_extended;
      temp_q     <= {1'b1, ea, temp_data};
    end else begin
      if (load && sel_rate) begin
        rate_q[gyro_spi_pkg::OUT_ND_BIT] <= 1'b0;
      end
      if (load && sel_temp) begin
        temp_q[gyro_spi_pkg::OUT_ND_BIT] <= 1'b0;
      end
    end
  end

  assign dout                       = dout_q;
  assign dout_oe                    = dout_oe_q;
  assign config_digital_line_one    = line_one_q;
  assign config_digital_line_one_oe = line_one_oe_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  dout_edge_only_a: assert property ($changed(dout_q) |-> $past(load || shift_out))
    else $error("dout changed without a falling clock or select edge");
  din_sampled_a: assert property (sclk_rise && in_shift && bits_q < 5'h10 |=> rx_q[0] == $past(din_s))
    else $error("input bit not captured on rising edge");
  oe_released_a: assert property (cs_n_s |=> !dout_oe_q)
    else $error("output driven while deselected");
  idle_when_high_a: assert property (cs_n_s && !cs_rise |=> $stable(bits_q))
    else $error("bit count moved while deselected");
  drdy_pulse_a: assert property (sample_end |=> line_one_q [*8])
    else $error("data ready pulse missing or short");
  sample_update_a: assert property (sample_end |=> rate_q[15] && temp_q[15])
    else $error("sample end did not refresh output words");
  msb_on_select_a: assert property (load |=> dout_q == $past(tx_word[15]))
    else $error("MSB not presented on select fall");
  read_answer_a: assert property (frame_ok && rx_q == 16'h0400 |=> tx_valid_q && sel_rate)
    else $error("rate request not queued for next frame");
  map_select_a: assert property (frame_ok && rx_q == 16'h0C00 |=> sel_temp)
    else $error("temperature request not selected");
  write_no_data_a: assert property (cs_rise && rx_q[15] |=> !tx_valid_q)
    else $error("answer queued after a write frame");
  byte_alias_a: assert property (frame_ok && rx_q[14:8] == 7'h07 |=> sel_ext)
    else $error("upper byte address did not select its word");
  duplex_a: assert property (load |=> tx_q == $past(tx_word) && bits_q == 5'h00)
    else $error("answer load did not restart the input count");

  read_frame_c: cover property (frame_ok && req_read);
  write_frame_c: cover property (frame_ok && !req_read);
  answer_sent_c: cover property (load ##[1:1000] cs_rise);
  drdy_seen_c: cover property (sample_end);

endmodule // gyro_spi_register_port

// *** sim/spi_master_model.sv ***
// Behavioural master processor that runs mode 3 frames on the serial port.
`timescale 1ns/10ps
module spi_master_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  // ---------------------------------------------------------------------------
  // Link state
  // ---------------------------------------------------------------------------
  // The bench may raise this to run a slow master.
  realtime half_ns = 62.5;
  logic    last_bit = 1'b0;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // One frame
  // ---------------------------------------------------------------------------
  // A released output line shows the inverse of its last level.
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx,
                       output logic oe_any, output logic msb_pre);
    logic line;
    cs_n = 1'b0;
    #250;
    msb_pre = dout_oe ? dout : ~last_bit;
    oe_any  = dout_oe;
    rx      = 16'h0000;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      din  = tx[15-i];
      #(half_ns);
      line     = dout_oe ? dout : ~last_bit;
      last_bit = line;
      rx       = {rx[14:0], line};
      oe_any   = oe_any | dout_oe;
      sclk     = 1'b1;
      #(half_ns);
    end
    #(half_ns);
    cs_n = 1'b1;
    din  = ~din;
    #9000;
  endtask
endmodule // spi_master_model

// *** sim/tb.sv ***
// Self-checking bench for the serial register port.
`timescale 1ns/10ps
module tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  // A short sample cycle keeps the run small; the pulse width stays 100 cycles.
  localparam int SMP = 300;
  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic [13:0] rate_data   = 14'h0D1D;
  logic [15:0] rate_ext    = 16'hA5C3;
  logic [13:0] temp_data   = 14'h1234;
  logic        alarm_flag  = 1'b0;
  logic        sclk, cs_n, din, dout, dout_oe, line_one, line_one_oe, oe, msb;
  logic [15:0] rx;
  int          error_cnt   = 0;
  int          n_checks    = 0;
  always #5 ref_clk = ~ref_clk;

  gyro_spi_register_port #(.SAMPLE_CYCLES(SMP)) gyro_spi_register_port_i (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .reset_pin_n(reset_pin_n),
    .rate_data(rate_data), .rate_output_extended(rate_ext), .temp_data(temp_data),
    .alarm_flag(alarm_flag), .dout(dout), .dout_oe(dout_oe), .config_digital_line_one(line_one),
    .config_digital_line_one_oe(line_one_oe));
  spi_master_model spi_master_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(logic [15:0] req, logic exp_oe, logic [15:0] exp);
    spi_master_model_i.frame(req, 16, rx, oe, msb);
    check("dout_oe", 16'(oe), 16'(exp_oe));
    if (exp_oe) begin
      check("answer", rx, exp);
      check("msb", 16'(msb), 16'(exp[15]));
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reads();
    logic [15:0] req [7] = '{16'h0600, 16'h0C00, 16'h0500, 16'h0700, 16'h0D00, 16'h0800, 16'h0400};
    logic [15:0] exp [7] = '{16'h8D1D, 16'hA5C3, 16'h9234, 16'h8D1D, 16'hA5C3, 16'h9234, 16'h0000};
    xfer(16'h0400, 1'b0, 16'h0000);
    for (int i = 0; i < 7; i++) xfer(req[i], 1'b1, exp[i]);
  endtask
  task automatic t_alarm();
    @(posedge ref_clk) alarm_flag <= 1'b1;
    repeat (SMP + 10) @(posedge ref_clk);
    xfer(16'h0C00, 1'b1, 16'hCD1D);
    xfer(16'h0400, 1'b1, 16'hD234);
    @(posedge ref_clk) alarm_flag <= 1'b0;
    repeat (SMP + 10) @(posedge ref_clk);
  endtask
  task automatic t_refuse();
    xfer(16'h8400, 1'b1, 16'h8D1D);
    xfer(16'h0400, 1'b0, 16'h0000);
    spi_master_model_i.frame(16'h0400, 8, rx, oe, msb);
    xfer(16'h0600, 1'b0, 16'h0000);
    spi_master_model_i.half_ns = 500.0;
    xfer(16'h0400, 1'b1, 16'hA5C3);
    spi_master_model_i.half_ns = 62.5;
    @(negedge ref_clk);
    check("idle_oe", 16'(dout_oe), 16'h0000);
  endtask
  // Waits for a pulse, then measures its width and the gap after it.
  task automatic t_drdy();
    int n = 0;
    int hi = 0;
    int lo = 0;
    while (line_one !== 1'b1 && n < SMP + 10) begin
      @(negedge ref_clk);
      n++;
    end
    while (line_one === 1'b1 && hi < SMP) begin
      @(negedge ref_clk);
      hi++;
    end
    while (line_one === 1'b0 && lo < SMP) begin
      @(negedge ref_clk);
      lo++;
    end
    check("pulse_high", 16'(hi), 16'h0064);
    check("pulse_gap", 16'(lo), 16'(SMP - 100));
    check("line_oe", 16'(line_one_oe), 16'h0001);
  endtask
  task automatic t_pin();
    int hi = 0;
    @(posedge ref_clk) reset_pin_n <= 1'b0;
    repeat (110) @(negedge ref_clk);
    repeat (2 * SMP) begin
      @(negedge ref_clk);
      if (line_one !== 1'b0) hi++;
    end
    check("held_pulses", 16'(hi), 16'h0000);
    @(posedge ref_clk) reset_pin_n <= 1'b1;
    t_drdy();
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check("reset_oe", 16'(dout_oe), 16'h0000);
    check("reset_line_oe", 16'(line_one_oe), 16'h0001);
    t_drdy();
    t_reads();
    t_alarm();
    t_refuse();
    t_pin();
    end_sim();
  end
  initial begin
    #900000;
    error_cnt++;
    end_sim();
  end
endmodule // tb
